// >>> include/dbt_pkg.sv
// Purpose: shared constants and types for the dual byte timer/counter
// Assumes: APB with 32-bit data; register indexes are not word aligned
// Notes:   byte address of a register is four times its index

package dbt_pkg;

    // ------------------------------------------------------------
    // register indexes (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_TIMER_CONTROL   = 16'hFE10;
    localparam logic [15:0] IDX_PRESCALER_MATCH = 16'hFE11;
    localparam logic [15:0] IDX_COUNT_LOW_BYTE  = 16'hFE12;
    localparam logic [15:0] IDX_COUNT_HIGH_BYTE = 16'hFE13;
    localparam logic [15:0] IDX_MATCH_DATA_LOW  = 16'hFE14;
    localparam logic [15:0] IDX_MATCH_DATA_HIGH = 16'hFE15;
    localparam logic [15:0] IDX_CAPTURE_LOW     = 16'hFE16;
    localparam logic [15:0] IDX_CAPTURE_HIGH    = 16'hFE17;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_PRESCALER = 8'h00;
    localparam logic [7:0] RST_MATCH     = 8'h00;
    localparam logic [7:0] RST_COUNT     = 8'h00;
    localparam int         POS_HIGH_FLAG = 3;
    localparam int         POS_LOW_FLAG  = 1;
    localparam int         MIN_ADDR_W    = 18;

    // interrupt vectors served by irq_high_r and irq_low_r
    localparam logic [15:0] VEC_HIGH_IRQ = 16'h0023;
    localparam logic [15:0] VEC_LOW_IRQ  = 16'h0013;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic high_run;
        logic low_run;
        logic length_select;
        logic low_clock_select;
        logic high_match_flag;
        logic high_irq_enable;
        logic low_match_flag;
        logic low_irq_enable;
    } dbt_ctrl_s;

    // synchronised pin events, one bit each
    typedef struct packed {
        logic cap_high;
        logic cap_low;
        logic ext_count;
    } dbt_pins_s;

endpackage

// >>> logic/dbt_timer.sv
// Purpose: dual 8-bit / single 16-bit timer/counter with prescaler and capture
// Assumes: single clock pclk; pin events are asynchronous and synchronised here
// Notes:   APB slave, one wait-free access cycle; capture registers have no reset
//
// How it works
// - high run off: high count held zero, high buffer follows high match data
// - high run on: high byte counts, buffer reloads only on match
// - low run off: low count held zero, low buffer follows low match data
// - low run on: low byte counts, buffer reloads only on match
// - length select 0: two independent 8-bit counters with own matches
// - length select 1: one 16-bit counter matching all 16 bits
// - low clock select picks prescaler pulse or external event for low byte
// - high match flag set by running match, cleared only by software
// - high enable and high flag raise the high interrupt request
// - low match flag set by running match, cleared only by software
// - low enable and low flag raise the low interrupt request
// - in 16-bit mode both flags set in the same cycle when high run is on, else only the low flag
// - any prescaler match write restarts the prescaler from zero
// - low count byte is read-only, counts prescaler or external events
// - high count byte is read-only, counts prescaler pulses or low carries
// - low capture latches low count on its capture event, no reset value
// - high capture latches high count on high capture event, no reset
// - prescaler pulses and restarts when count equals its match value
// - count bytes return to zero when stopped or on match
// - length select picks high byte clock: prescaler or low byte chain
// - low capture uses low inputs in 8-bit, high inputs in 16-bit mode

`timescale 1ns/1ns
`default_nettype none

module dbt_timer #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // asynchronous pins
    input  wire dbt_pkg::dbt_pins_s    pins_in,
    // interrupt requests
    output logic                       irq_high,
    output logic                       irq_low
);
    import dbt_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < MIN_ADDR_W) begin : g_chk_addr
        $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    dbt_ctrl_s   ctrl_r;
    logic [7:0]  prr_r;
    logic [7:0]  pre_cnt_r;
    logic        pre_tick_r;
    logic [7:0]  cnt_low_r;
    logic [7:0]  cnt_high_r;
    logic [7:0]  data_low_r;
    logic [7:0]  data_high_r;
    logic [7:0]  buf_low_r;
    logic [7:0]  buf_high_r;
    logic [7:0]  cap_low_r;
    logic [7:0]  cap_high_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_high_r;
    logic        irq_low_r;
    dbt_pins_s   sync1_r;
    dbt_pins_s   sync2_r;
    dbt_pins_s   prev_r;
    dbt_pins_s   edge_w;
    logic        wr_en;
    logic        setup;
    logic [7:0]  rd_nxt;
    logic        hit_nxt;
    logic        low_tick;
    logic        low_hit;
    logic        high_hit;
    logic        match_long;
    logic        match_low;
    logic        match_high;
    logic        low_carry;
    logic        cap_low_trig;
    logic [7:0]  ctrl_nxt;

    // byte address of a register from its index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = ADDR_W'({idx, 2'b00});
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    // two flops per pin; the edge detector reads the second flop and its delayed copy prev_r
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // rising edge of each synchronised pin is one detection event
    assign edge_w = sync2_r & ~prev_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite;

    // read data and address check, sampled in the setup cycle
    always_comb begin
        rd_nxt  = 8'h00;
        hit_nxt = 1'b1;
        if (paddr == reg_addr(IDX_TIMER_CONTROL)) begin
            rd_nxt = ctrl_r;
        end else if (paddr == reg_addr(IDX_PRESCALER_MATCH)) begin
            rd_nxt = prr_r;
        end else if (paddr == reg_addr(IDX_COUNT_LOW_BYTE)) begin
            rd_nxt = cnt_low_r;
        end else if (paddr == reg_addr(IDX_COUNT_HIGH_BYTE)) begin
            rd_nxt = cnt_high_r;
        end else if (paddr == reg_addr(IDX_MATCH_DATA_LOW)) begin
            rd_nxt = data_low_r;
        end else if (paddr == reg_addr(IDX_MATCH_DATA_HIGH)) begin
            rd_nxt = data_high_r;
        end else if (paddr == reg_addr(IDX_CAPTURE_LOW)) begin
            rd_nxt = cap_low_r;
        end else if (paddr == reg_addr(IDX_CAPTURE_HIGH)) begin
            rd_nxt = cap_high_r;
        end else begin
            hit_nxt = 1'b0;
        end
    end

    // one access cycle; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~hit_nxt;
            if (setup) begin
                prdata_r <= {24'h00_0000, rd_nxt};
            end
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    // count and capture indexes have no write path at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prr_r       <= RST_PRESCALER;
            data_low_r  <= RST_MATCH;
            data_high_r <= RST_MATCH;
        end else if (wr_en) begin
            if (paddr == reg_addr(IDX_PRESCALER_MATCH)) begin
                prr_r <= pwdata[7:0];
            end else if (paddr == reg_addr(IDX_MATCH_DATA_LOW)) begin
                data_low_r <= pwdata[7:0];
            end else if (paddr == reg_addr(IDX_MATCH_DATA_HIGH)) begin
                data_high_r <= pwdata[7:0];
            end
        end
    end

    // control: a match in the clearing cycle keeps its flag set
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en && paddr == reg_addr(IDX_TIMER_CONTROL)) begin
            ctrl_nxt = pwdata[7:0];
        end
        ctrl_nxt[POS_HIGH_FLAG] = ctrl_nxt[POS_HIGH_FLAG] | match_high;
        ctrl_nxt[POS_LOW_FLAG]  = ctrl_nxt[POS_LOW_FLAG] | match_low;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= RST_CONTROL;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // period prr_r + 1 cycles; a write restarts so the first period is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r  <= RST_COUNT;
            pre_tick_r <= 1'b0;
        end else if (wr_en && paddr == reg_addr(IDX_PRESCALER_MATCH)) begin
            pre_cnt_r  <= RST_COUNT;
            pre_tick_r <= 1'b0;
        end else if (pre_cnt_r == prr_r) begin
            pre_cnt_r  <= RST_COUNT;
            pre_tick_r <= 1'b1;
        end else begin
            pre_cnt_r  <= pre_cnt_r + 8'h01;
            pre_tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // match detection
    // ------------------------------------------------------------
    always_comb begin
        low_tick   = ctrl_r.low_clock_select ? edge_w.ext_count : pre_tick_r;
        low_hit    = cnt_low_r == buf_low_r;
        high_hit   = cnt_high_r == buf_high_r;
        match_long = ctrl_r.low_run & low_tick & low_hit & high_hit;
        low_carry  = ctrl_r.low_run & low_tick & (cnt_low_r == 8'hFF);
        if (ctrl_r.length_select) begin
            match_low  = match_long;
            match_high = match_long & ctrl_r.high_run;
        end else begin
            match_low  = ctrl_r.low_run & low_tick & low_hit;
            match_high = ctrl_r.high_run & pre_tick_r & high_hit;
        end
    end

    // ------------------------------------------------------------
    // low count byte and its buffer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_low_r <= RST_COUNT;
            buf_low_r <= RST_MATCH;
        end else if (!ctrl_r.low_run) begin
            cnt_low_r <= RST_COUNT;
            buf_low_r <= data_low_r;
        end else if (match_low) begin
            cnt_low_r <= RST_COUNT;
            buf_low_r <= data_low_r;
        end else if (low_tick) begin
            cnt_low_r <= cnt_low_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // high count byte and its buffer
    // ------------------------------------------------------------
    // in 16-bit mode the high byte advances on low byte carries only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_high_r <= RST_COUNT;
            buf_high_r <= RST_MATCH;
        end else if (!ctrl_r.high_run) begin
            cnt_high_r <= RST_COUNT;
            buf_high_r <= data_high_r;
        end else if (match_high || (ctrl_r.length_select && match_long)) begin
            cnt_high_r <= RST_COUNT;
            buf_high_r <= data_high_r;
        end else if (ctrl_r.length_select ? low_carry : pre_tick_r) begin
            cnt_high_r <= cnt_high_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // capture registers (no reset, contents undefined until first event)
    // ------------------------------------------------------------
    assign cap_low_trig = ctrl_r.length_select ? edge_w.cap_high : edge_w.cap_low;

    always_ff @(posedge pclk) begin
        if (cap_low_trig) begin
            cap_low_r <= cnt_low_r;
        end
        if (edge_w.cap_high) begin
            cap_high_r <= cnt_high_r;
        end
    end

    // ------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high_r <= 1'b0;
            irq_low_r  <= 1'b0;
        end else begin
            irq_high_r <= ctrl_r.high_irq_enable & ctrl_r.high_match_flag;
            irq_low_r  <= ctrl_r.low_irq_enable & ctrl_r.low_match_flag;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign irq_high = irq_high_r;
    assign irq_low  = irq_low_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_low_stop_zero: assert property (!ctrl_r.low_run |=> cnt_low_r == 8'h00)
        else $error("low count not zero while stopped");
    chk_high_stop_zero: assert property (!ctrl_r.high_run |=> cnt_high_r == 8'h00)
        else $error("high count not zero while stopped");
    chk_low_buf_follow: assert property (!ctrl_r.low_run |=> buf_low_r == $past(data_low_r))
        else $error("low buffer not following match data");
    chk_high_buf_hold: assert property (ctrl_r.high_run && !match_high && !match_long
        |=> buf_high_r == $past(buf_high_r))
        else $error("high buffer changed without match");
    chk_pre_restart: assert property (wr_en && paddr == reg_addr(IDX_PRESCALER_MATCH)
        |=> pre_cnt_r == 8'h00 && !pre_tick_r)
        else $error("prescaler not restarted by write");
    // a four-cycle period is the one the high byte scenario runs long enough to see
    chk_pre_period: assert property (pre_tick_r && prr_r == 8'h03 && !wr_en
        ##1 !wr_en ##1 !wr_en ##1 !wr_en |=> pre_tick_r)
        else $error("prescaler period wrong");
    chk_low_flag_set: assert property (match_low |=> ctrl_r.low_match_flag)
        else $error("low flag not set on match");
    chk_high_flag_set: assert property (match_high |=> ctrl_r.high_match_flag)
        else $error("high flag not set on match");
    chk_flag_sticky: assert property (ctrl_r.low_match_flag && !wr_en |=> ctrl_r.low_match_flag)
        else $error("low flag cleared by hardware");
    chk_flags_together: assert property (ctrl_r.length_select && ctrl_r.high_run && match_long
        |=> ctrl_r.low_match_flag && ctrl_r.high_match_flag)
        else $error("16-bit match did not set both flags");
    chk_irq_high: assert property (ctrl_r.high_irq_enable && ctrl_r.high_match_flag
        |=> irq_high_r)
        else $error("high interrupt missing");
    chk_irq_low: assert property (irq_low_r |-> $past(ctrl_r.low_irq_enable && ctrl_r.low_match_flag))
        else $error("low interrupt without cause");
    chk_low_match_zero: assert property (match_low |=> cnt_low_r == 8'h00)
        else $error("low count not reset on match");
    chk_capture_low: assert property (cap_low_trig |=> cap_low_r == $past(cnt_low_r))
        else $error("low capture wrong");
    chk_capture_high: assert property (edge_w.cap_high |=> cap_high_r == $past(cnt_high_r))
        else $error("high capture wrong");
    // the chained byte must advance by one on every low carry that is not a match
    chk_long_carry: assert property (ctrl_r.length_select && ctrl_r.high_run && low_carry && !match_long
        |=> cnt_high_r == $past(cnt_high_r) + 8'h01)
        else $error("high byte missed a low carry");

    // main scenarios: long match, external count, captures, low interrupt
    cov_long_match: cover property (ctrl_r.length_select && match_long);
    cov_long_capture: cover property (ctrl_r.length_select && cap_low_trig);
    cov_ext_count:  cover property (ctrl_r.low_clock_select && ctrl_r.low_run && low_tick);
    cov_capture:    cover property (edge_w.cap_high);
    cov_irq_low:    cover property (irq_low_r);

endmodule

`default_nettype wire

// >>> tb/dbt_apb_master.sv
// Purpose: core-side apb master that issues register transfers to the timer
// Assumes: one transfer at a time; caller may enter at any moment
// Notes:   a transfer starts one edge after entry, so releases never collide
`timescale 1ns/1ns
`default_nettype none

module dbt_apb_master #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb request
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata,
    // apb answer
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    // --------------------------------------------------------
    // idle levels
    // --------------------------------------------------------
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = 32'h0000_0000;
    end

    // one whole transfer; byte address is four times the index
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        // a request made while the core is held in reset would be lost
        while (presetn !== 1'b1) @(posedge pclk);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ADDR_W'({idx, 2'b00});
        pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the slave as long as it takes; only the bench watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the dual byte timer/counter
// Assumes: pins are driven here, registers through the apb master model
// Notes:   cycle figures allow for the two-flop pin synchroniser
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import dbt_pkg::*;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr, irq_high, irq_low;
    logic [17:0]       paddr;
    logic [31:0]       pwdata, prdata;
    dbt_pins_s         pins_in = '0;
    int                err_count = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    logic [7:0]        rv;
    logic              ev;

    // --------------------------------------------------------
    // clock, reset, cycle count
    // --------------------------------------------------------
    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    dbt_timer #(.ADDR_W(18)) dbt_timer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_in(pins_in), .irq_high(irq_high), .irq_low(irq_low));

    dbt_apb_master #(.ADDR_W(18)) dbt_apb_master_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // --------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        dbt_apb_master_i.xfer(1'b1, idx, d, rv, ev);
    endtask

    task automatic rd(input logic [15:0] idx);
        dbt_apb_master_i.xfer(1'b0, idx, 8'h00, rv, ev);
    endtask

    // wait, bounded, until the chosen request line shows the level
    task automatic wait_irq(input logic hi, input logic lvl);
        int n;
        n = 0;
        while (((hi ? irq_high : irq_low) !== lvl) && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // one rising edge on a pin, long enough for the synchroniser
    task automatic pulse(input int b);
        @(posedge pclk);
        pins_in[b] <= 1'b1;
        repeat (3) @(posedge pclk);
        pins_in[b] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic give_verdict();
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic s_reset_map();
        for (int i = 0; i < 6; i++) begin
            rd(IDX_TIMER_CONTROL + 16'(i));
            check({8'h00, rv}, 16'h0000);
        end
        wr(IDX_MATCH_DATA_LOW, 8'h5A);
        rd(IDX_MATCH_DATA_LOW);
        check({8'h00, rv}, 16'h005A);
        rd(16'hFE18); // unmapped index
        check({7'h00, ev, rv}, 16'h0100);
    endtask

    task automatic s_low_8bit();
        wr(IDX_PRESCALER_MATCH, 8'h00);
        wr(IDX_MATCH_DATA_LOW, 8'h02);
        wr(IDX_TIMER_CONTROL, 8'h41);
        wait_irq(1'b0, 1'b1);
        check({15'h0, irq_low}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            rd(IDX_COUNT_LOW_BYTE);
            check({15'h0, rv <= 8'h02}, 16'h0001);
        end
        wr(IDX_TIMER_CONTROL, 8'h02);
        repeat (10) @(posedge pclk);
        rd(IDX_TIMER_CONTROL);
        check({8'h00, rv}, 16'h0002);
        check({15'h0, irq_low}, 16'h0000);
        rd(IDX_COUNT_LOW_BYTE);
        check({8'h00, rv}, 16'h0000);
        wr(IDX_TIMER_CONTROL, 8'h00);
    endtask

    task automatic s_high_prescale();
        int t1;
        wr(IDX_PRESCALER_MATCH, 8'h07);
        wr(IDX_MATCH_DATA_HIGH, 8'h01);
        wr(IDX_TIMER_CONTROL, 8'h84);
        // restarts every few cycles starve the 8-cycle prescaler of any tick
        for (int i = 0; i < 10; i++) wr(IDX_PRESCALER_MATCH, 8'h07);
        rd(IDX_TIMER_CONTROL);
        check({8'h00, rv}, 16'h0084);
        wr(IDX_PRESCALER_MATCH, 8'h03);
        wait_irq(1'b1, 1'b1);
        t1 = cyc;
        wr(IDX_TIMER_CONTROL, 8'h84);
        wait_irq(1'b1, 1'b0);
        wait_irq(1'b1, 1'b1);
        check(16'(cyc - t1), 16'd8);
        check({15'h0, irq_low}, 16'h0000);
        wr(IDX_TIMER_CONTROL, 8'h00);
    endtask

    task automatic s_16bit();
        int t0;
        wr(IDX_PRESCALER_MATCH, 8'h00);
        wr(IDX_MATCH_DATA_LOW, 8'h03);
        wr(IDX_MATCH_DATA_HIGH, 8'h01);
        wr(IDX_TIMER_CONTROL, 8'hE5);
        t0 = cyc;
        wait_irq(1'b0, 1'b1);
        check({15'h0, irq_high}, 16'h0001);
        t0 = cyc - t0;
        check({15'h0, t0 >= 258 && t0 <= 266}, 16'h0001);
        wr(IDX_TIMER_CONTROL, 8'h00);
    endtask

    task automatic s_ext_capture();
        wr(IDX_MATCH_DATA_LOW, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'h50);
        for (int i = 0; i < 5; i++) pulse(0);
        rd(IDX_COUNT_LOW_BYTE);
        check({8'h00, rv}, 16'h0005);
        pulse(1);
        wr(IDX_COUNT_LOW_BYTE, 8'hAA);
        wr(IDX_CAPTURE_LOW, 8'hAA);
        rd(IDX_CAPTURE_LOW);
        check({7'h00, ev, rv}, 16'h0005);
        rd(IDX_COUNT_LOW_BYTE);
        check({8'h00, rv}, 16'h0005);
        pulse(2);
        rd(IDX_CAPTURE_HIGH);
        check({8'h00, rv}, 16'h0000);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rd(IDX_COUNT_LOW_BYTE);
        check({8'h00, rv}, 16'h0000);
    endtask

    // 16-bit external counting; low capture now follows the high capture pin
    task automatic s_long_ext_capture();
        wr(IDX_MATCH_DATA_LOW, 8'hFF);
        wr(IDX_MATCH_DATA_HIGH, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'hF0);
        for (int i = 0; i < 3; i++) pulse(0);
        pulse(1);
        rd(IDX_CAPTURE_LOW);
        check({8'h00, rv}, 16'h0005);
        pulse(2);
        rd(IDX_CAPTURE_LOW);
        check({8'h00, rv}, 16'h0003);
        rd(IDX_CAPTURE_HIGH);
        check({8'h00, rv}, 16'h0000);
        wr(IDX_TIMER_CONTROL, 8'h00);
    endtask

    // --------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_reset_map();
        s_low_8bit();
        s_high_prescale();
        s_16bit();
        s_ext_capture();
        s_long_ext_capture();
        give_verdict();
    end

    // generous for the under one thousand cycles of scenarios
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
